// file: inc/dec_consts.svh
// named constants for the digital event counter bank
// assumes inclusion by bare name from package and design files
`ifndef DEC_CONSTS_SVH
`define DEC_CONSTS_SVH
`define DEC_NUM_CNT 8
`define DEC_CW 32
`define DEC_RST_WORD 32'h0000_0000
`define DEC_MAX_POS 32'h7fff_ffff
`define DEC_MAX_NEG 32'h8000_0000
`define DEC_REG_CTRL 12'h000
`define DEC_REG_IRQ_STAT 12'h004
`define DEC_REG_IRQ_EN 12'h008
`define DEC_REG_IRQ_CLR 12'h00c
`define DEC_REG_NV_STAT 12'h010
`define DEC_CNT_PAGE 4'h1
`define DEC_F_PRESET 3'h0
`define DEC_F_COMPARE 3'h1
`define DEC_F_ACC 3'h2
`define DEC_F_FROZEN 3'h3
`define DEC_F_FTIME 3'h4
`define DEC_IRQ_FRZ_LSB 0
`define DEC_IRQ_EQ_LSB 8
`define DEC_IRQ_NV_BIT 16
`define DEC_IRQ_W 17
`define DEC_NV_WORDS 5'h10
`define DEC_HTRANS_NONSEQ 2'h2
`endif

// file: inc/dec_pkg.sv
// types for the digital event counter bank
// assumes dec_consts.svh is on the include path
`include "dec_consts.svh"
package dec_pkg;
   typedef enum logic [1:0] {NV_IDLE, NV_SAVE, NV_DONE} dec_nv_state_type;
   typedef logic signed [`DEC_CW-1:0] dec_count_type;
endpackage

// file: logic/dec_counter_bank.sv
// bank of signed event counters with setpoint compare, freeze and nv save
// assumes operands come from same-clock logic, one pass per pass_strobe
//
// How it works
// (RL1) eight counters, identical, separate settings
// (RL2) count only rising edges of operands
// (RL3) up adds one, wraps max to min
// (RL4) down subtracts one, wraps min to max
// (RL5) exactly one of above/equal/below flags
// (RL6) block stops counting, forces flags low
// (RL7) on enable load preset or zero
// (RL8) preset-select rising edge loads preset
// (RL9) reset commands load preset or zero
// (RL10) freeze-reset captures value and time, resets
// (RL11) freeze-count captures value and time, continues
// (RL12) power loss saves values to nv storage
// (RL13) signed 32-bit, edges against previous pass
// (RL14) up plus down cancels; loads beat counting
`timescale 1ns/1ps
`include "dec_consts.svh"
`default_nettype none
module dec_counter_bank
   import dec_pkg::*;
#(
   parameter int NUM_CNT = `DEC_NUM_CNT
) (
   input wire logic clk,
   input wire logic srst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // operands from host logic
   input wire logic pass_strobe,
   input wire logic [NUM_CNT-1:0] up_op,
   input wire logic [NUM_CNT-1:0] down_op,
   input wire logic [NUM_CNT-1:0] block_op,
   input wire logic [NUM_CNT-1:0] preset_select_operand,
   input wire logic [NUM_CNT-1:0] reset_op,
   input wire logic [NUM_CNT-1:0] freeze_reset_op,
   input wire logic [NUM_CNT-1:0] freeze_count_op,
   input wire logic [31:0] timestamp,
   // compare results
   output logic [NUM_CNT-1:0] count_above_setpoint,
   output logic [NUM_CNT-1:0] count_equals_setpoint,
   output logic [NUM_CNT-1:0] count_below_setpoint,
   // power loss pin, nv write port and interrupt
   input wire logic power_fail_pin,
   output logic nv_we,
   output logic [4:0] nv_addr,
   output logic [31:0] nv_wdata,
   output logic irq
);

   // per counter settings and state
   dec_count_type preset_q [NUM_CNT]; // preset value
   dec_count_type compare_q [NUM_CNT]; // setpoint
   dec_count_type acc_q [NUM_CNT]; // accumulated count
   dec_count_type acc_d [NUM_CNT];
   dec_count_type frozen_q [NUM_CNT]; // frozen count
   logic [31:0] ftime_q [NUM_CNT]; // frozen time stamp
   dec_count_type load_val [NUM_CNT]; // preset or zero
   logic [NUM_CNT-1:0] en_q; // software enables
   logic [NUM_CNT-1:0] en_prev_q; // enable seen at last pass
   // operand values of the previous pass
   logic [NUM_CNT-1:0] up_prev_q, dn_prev_q, pre_prev_q;
   logic [NUM_CNT-1:0] rst_prev_q, frs_prev_q, frc_prev_q;
   // rising edges of this pass
   logic [NUM_CNT-1:0] up_rise, dn_rise, pre_rise, rst_rise, frs_rise, frc_rise;
   logic [NUM_CNT-1:0] en_rise, run, load_cmd, frz_cmd, eq_prev_q;

   // edge detection against previous pass
   assign up_rise = up_op & ~up_prev_q; // RL2
   assign dn_rise = down_op & ~dn_prev_q; // RL2
   assign pre_rise = preset_select_operand & ~pre_prev_q; // RL8
   assign rst_rise = reset_op & ~rst_prev_q;
   assign frs_rise = freeze_reset_op & ~frs_prev_q;
   assign frc_rise = freeze_count_op & ~frc_prev_q;
   assign en_rise = en_q & ~en_prev_q;
   assign run = en_q & ~en_rise;
   assign load_cmd = run & (rst_rise | frs_rise); // RL9
   assign frz_cmd = {NUM_CNT{pass_strobe}} & run & (frs_rise | frc_rise); // RL10 RL11

   // next count per counter
   always_comb begin
      for (int i = 0; i < NUM_CNT; i++) begin
         load_val[i] = preset_select_operand[i] ? preset_q[i] : `DEC_RST_WORD; // RL7 RL9
         acc_d[i] = acc_q[i];
         if (!pass_strobe) begin
            acc_d[i] = acc_q[i]; // only act once per pass, RL13
         end else if (en_rise[i] || load_cmd[i]) begin
            acc_d[i] = load_val[i]; // RL7 RL9 RL10 RL14
         end else if (run[i] && pre_rise[i]) begin
            acc_d[i] = preset_q[i]; // RL8 RL14
         end else if (run[i] && !block_op[i]) begin
            if (up_rise[i] && !dn_rise[i]) begin
               // RL3
               acc_d[i] = (acc_q[i] == `DEC_MAX_POS) ? `DEC_MAX_NEG : acc_q[i] + 32'sh1;
            end else if (dn_rise[i] && !up_rise[i]) begin
               // RL4
               acc_d[i] = (acc_q[i] == `DEC_MAX_NEG) ? `DEC_MAX_POS : acc_q[i] - 32'sh1;
            end
         end
      end
   end

   // counters and freeze captures; edge history is kept in the next block
   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_CNT; i++) begin // RL1
         if (srst) begin
            acc_q[i] <= `DEC_RST_WORD;
            frozen_q[i] <= `DEC_RST_WORD;
            ftime_q[i] <= `DEC_RST_WORD;
         end else begin
            acc_q[i] <= acc_d[i];
            if (frz_cmd[i]) begin
               frozen_q[i] <= acc_q[i]; // RL10 RL11
               ftime_q[i] <= timestamp;
            end
         end
      end
   end

   // previous-pass operand values
   always_ff @(posedge clk) begin
      if (srst) begin
         {up_prev_q, dn_prev_q, pre_prev_q} <= '0;
         {rst_prev_q, frs_prev_q, frc_prev_q, en_prev_q} <= '0;
      end else if (pass_strobe) begin
         {up_prev_q, dn_prev_q, pre_prev_q} <= {up_op, down_op, preset_select_operand}; // RL13
         {rst_prev_q, frs_prev_q, frc_prev_q} <= {reset_op, freeze_reset_op, freeze_count_op};
         en_prev_q <= en_q;
      end
   end

   // setpoint compare flags, held low when blocked or disabled
   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_CNT; i++) begin
         if (srst || block_op[i] || !en_q[i]) begin
            count_above_setpoint[i] <= 1'b0; // RL6
            count_equals_setpoint[i] <= 1'b0;
            count_below_setpoint[i] <= 1'b0;
         end else begin
            count_above_setpoint[i] <= acc_q[i] > compare_q[i]; // RL5
            count_equals_setpoint[i] <= acc_q[i] == compare_q[i];
            count_below_setpoint[i] <= acc_q[i] < compare_q[i];
         end
      end
   end

   // power-fail pin synchroniser and nv save sequencer
   logic pf_s1_q, pf_s2_q, pf_s3_q;
   dec_nv_state_type nv_state_q;
   logic [4:0] nv_idx_q; // word being saved
   logic nv_done_pulse;
   wire pf_rise = pf_s2_q & ~pf_s3_q;
   wire [2:0] nv_cnt = nv_idx_q[2:0];
   assign nv_done_pulse = (nv_state_q == NV_SAVE) && (nv_idx_q == `DEC_NV_WORDS - 5'h1);

   always_ff @(posedge clk) begin
      if (srst) begin
         {pf_s1_q, pf_s2_q, pf_s3_q} <= 3'h0;
      end else begin
         {pf_s1_q, pf_s2_q, pf_s3_q} <= {power_fail_pin, pf_s1_q, pf_s2_q};
      end
   end

   // writes acc words 0..7 then frozen words 8..15, one per clock
   always_ff @(posedge clk) begin
      if (srst) begin
         nv_state_q <= NV_IDLE;
         nv_idx_q <= 5'h0;
         nv_we <= 1'b0;
         nv_addr <= 5'h0;
         nv_wdata <= `DEC_RST_WORD;
      end else begin
         nv_we <= 1'b0;
         case (nv_state_q)
            NV_IDLE: begin
               if (pf_rise) begin
                  nv_state_q <= NV_SAVE; // RL12
                  nv_idx_q <= 5'h0;
               end
            end
            NV_SAVE: begin
               nv_we <= 1'b1; // RL12
               nv_addr <= nv_idx_q;
               nv_wdata <= nv_idx_q[3] ? frozen_q[nv_cnt] : acc_q[nv_cnt];
               nv_idx_q <= nv_idx_q + 5'h1;
               if (nv_done_pulse) begin
                  nv_state_q <= NV_DONE;
               end
            end
            NV_DONE: begin
               nv_state_q <= NV_DONE; // stays until reset
            end
            default: begin
               nv_state_q <= NV_IDLE;
            end
         endcase
      end
   end

   // ahb-lite address phase capture
   logic [11:0] wa_q; // write address held for data phase
   logic wr_pend_q;
   wire addr_ok = hsel & hready & (htrans == `DEC_HTRANS_NONSEQ);
   wire [11:0] ra = haddr[11:0];
   wire rd_page = (ra[11:8] == `DEC_CNT_PAGE);
   wire [2:0] rd_cnt = ra[7:5];
   wire [2:0] rd_fld = ra[4:2];
   wire wr_page = (wa_q[11:8] == `DEC_CNT_PAGE);
   wire [2:0] wr_cnt = wa_q[7:5];
   wire [2:0] wr_fld = wa_q[4:2];
   logic [`DEC_IRQ_W-1:0] ist_q, ien_q, ist_ev, ist_clr;
   logic [31:0] rd_word;

   // read decode, unmapped reads as zero
   always_comb begin
      rd_word = 32'h0;
      if (rd_page) begin
         case (rd_fld)
            `DEC_F_PRESET: rd_word = preset_q[rd_cnt];
            `DEC_F_COMPARE: rd_word = compare_q[rd_cnt];
            `DEC_F_ACC: rd_word = acc_q[rd_cnt];
            `DEC_F_FROZEN: rd_word = frozen_q[rd_cnt];
            `DEC_F_FTIME: rd_word = ftime_q[rd_cnt];
            default: rd_word = 32'h0;
         endcase
      end else begin
         case (ra)
            `DEC_REG_CTRL: rd_word = {{(32-NUM_CNT){1'b0}}, en_q};
            `DEC_REG_IRQ_STAT: rd_word = {{(32-`DEC_IRQ_W){1'b0}}, ist_q};
            `DEC_REG_IRQ_EN: rd_word = {{(32-`DEC_IRQ_W){1'b0}}, ien_q};
            `DEC_REG_NV_STAT: rd_word = {30'h0, nv_state_q == NV_DONE, nv_state_q == NV_SAVE};
            default: rd_word = 32'h0;
         endcase
      end
   end

   // bus response: zero wait, always okay, read data latched at address phase
   always_ff @(posedge clk) begin
      if (srst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
         wr_pend_q <= 1'b0;
         wa_q <= 12'h0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= addr_ok & hwrite;
         if (addr_ok) begin
            wa_q <= ra;
            hrdata <= hwrite ? 32'h0 : rd_word;
         end
      end
   end

   // register writes in the data phase
   wire wr_now = wr_pend_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         en_q <= '0;
         ien_q <= '0;
         for (int i = 0; i < NUM_CNT; i++) begin
            preset_q[i] <= `DEC_RST_WORD;
            compare_q[i] <= `DEC_RST_WORD;
         end
      end else if (wr_now) begin
         if (wr_page && wr_fld == `DEC_F_PRESET) begin
            preset_q[wr_cnt] <= hwdata;
         end else if (wr_page && wr_fld == `DEC_F_COMPARE) begin
            compare_q[wr_cnt] <= hwdata;
         end else if (!wr_page && wa_q == `DEC_REG_CTRL) begin
            en_q <= hwdata[NUM_CNT-1:0];
         end else if (!wr_page && wa_q == `DEC_REG_IRQ_EN) begin
            ien_q <= hwdata[`DEC_IRQ_W-1:0];
         end
      end
   end

   // sticky status: set beats clear
   assign ist_ev[`DEC_IRQ_FRZ_LSB +: NUM_CNT] = frz_cmd;
   assign ist_ev[`DEC_IRQ_EQ_LSB +: NUM_CNT] = count_equals_setpoint & ~eq_prev_q;
   assign ist_ev[`DEC_IRQ_NV_BIT] = nv_done_pulse;
   assign ist_clr = (wr_now && !wr_page && wa_q == `DEC_REG_IRQ_CLR) ?
                    hwdata[`DEC_IRQ_W-1:0] : '0;
   always_ff @(posedge clk) begin
      if (srst) begin
         ist_q <= '0;
         eq_prev_q <= '0;
         irq <= 1'b0;
      end else begin
         ist_q <= (ist_q & ~ist_clr) | ist_ev;
         eq_prev_q <= count_equals_setpoint;
         irq <= |(ist_q & ien_q);
      end
   end

   // checks on counter 0 and the nv save sequencer
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_up_wrap_limit: assert property ( // RL3
      pass_strobe && run[0] && !load_cmd[0] && !pre_rise[0] && !block_op[0]
      && up_rise[0] && !dn_rise[0] && acc_q[0] == `DEC_MAX_POS
      |=> acc_q[0] == `DEC_MAX_NEG) else $error("up did not wrap");
   a_down_wrap_limit: assert property ( // RL4
      pass_strobe && run[0] && !load_cmd[0] && !pre_rise[0] && !block_op[0]
      && dn_rise[0] && !up_rise[0] && acc_q[0] == `DEC_MAX_NEG
      |=> acc_q[0] == `DEC_MAX_POS) else $error("down did not wrap");
   a_flags_one_hot: assert property ( // RL5
      en_q[0] && $past(en_q[0]) && !block_op[0] && !$past(block_op[0]) |->
      $onehot({count_above_setpoint[0], count_equals_setpoint[0],
      count_below_setpoint[0]})) else $error("compare flags not one-hot");
   a_block_flags_low: assert property ( // RL6
      block_op[0] |=> !count_above_setpoint[0] && !count_equals_setpoint[0]
      && !count_below_setpoint[0]) else $error("flags high while blocked");
   a_enable_load_val: assert property ( // RL7
      pass_strobe && en_rise[0] |=> acc_q[0] == $past(load_val[0]))
      else $error("enable load wrong");
   a_preset_edge_load: assert property ( // RL8
      pass_strobe && run[0] && !load_cmd[0] && pre_rise[0]
      |=> acc_q[0] == $past(preset_q[0])) else $error("preset edge not loaded");
   a_reset_cmd_load: assert property ( // RL9
      pass_strobe && load_cmd[0] |=> acc_q[0] == $past(load_val[0]))
      else $error("reset command load wrong");
   a_freeze_capture: assert property ( // RL10
      frz_cmd[0] |=> frozen_q[0] == $past(acc_q[0]) && ftime_q[0] == $past(timestamp))
      else $error("freeze capture wrong");
   a_no_edge_hold: assert property ( // RL2
      pass_strobe && run[0] && !load_cmd[0] && !pre_rise[0] && !up_rise[0]
      && !dn_rise[0] |=> $stable(acc_q[0])) else $error("count moved without edge");
   a_up_down_cancel: assert property ( // RL14
      pass_strobe && run[0] && !load_cmd[0] && !pre_rise[0] && up_rise[0]
      && dn_rise[0] |=> $stable(acc_q[0])) else $error("up and down did not cancel");
   a_nv_save_done: assert property ( // RL12
      nv_state_q == NV_IDLE && pf_rise |-> ##[17:18] nv_state_q == NV_DONE)
      else $error("nv save did not finish");

   c_up_count: cover property (pass_strobe && run[0] && up_rise[0] && !block_op[0]);
   c_freeze_reset: cover property (frz_cmd[0] && frs_rise[0]);
   c_nv_saved: cover property (nv_done_pulse);
   c_irq_raised: cover property (!irq ##1 irq);

endmodule
`default_nettype wire

// file: dv/dec_operand_model.sv
// host operand network model: one pass strobe per request, levels held between
// assumes the bench asks for a pass with a one-cycle go, on the same clock
`timescale 1ns/1ps
`default_nettype none
module dec_operand_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic go,
   input wire logic [55:0] want,
   output logic pass_strobe,
   output logic [55:0] ops,
   output logic [31:0] timestamp
);
   // operands move only together with the strobe, so each pass sees one set
   always_ff @(posedge clk) begin
      if (srst) begin
         pass_strobe <= 1'b0;
         ops <= '0;
      end else begin
         pass_strobe <= go;
         if (go) begin
            ops <= want;
         end
      end
   end
   // free running date and time word
   always_ff @(posedge clk) begin
      if (srst) begin
         timestamp <= 32'h0000_0000;
      end else begin
         timestamp <= timestamp + 32'h0000_0001;
      end
   end
endmodule
`default_nettype wire

// file: dv/test_digital_event_counter.sv
// self-checking bench: operand passes, register bus, interrupts, power loss save
// assumes dec_operand_model as the operand source and a 10 MHz clock
`timescale 1ns/1ps
`include "dec_consts.svh"
`default_nettype none
module test_digital_event_counter;
   import dec_pkg::*;
   // row: operands {fc,fr,rst,ps,blk,dn,up}, count, flags {above,equal,below}
   typedef struct packed {logic [6:0] op; logic [31:0] acc; logic [2:0] fl;} dec_row_type;
   logic clk, srst, hsel, hwrite, go, power_fail_pin, hreadyout, hresp, pass_strobe, nv_we, irq;
   logic [31:0] haddr, hwdata, hrdata, timestamp, rd, ts_exp, nv_wdata;
   logic [1:0] htrans;
   logic [55:0] want, ops, w;
   logic [7:0] above, equal, below;
   logic [4:0] nv_addr;
   int error_cnt, check_count, nv_n;
   dec_row_type rows[22];
   dec_operand_model u_dec_operand_model (.clk(clk), .srst(srst), .go(go), .want(want),
      .pass_strobe(pass_strobe), .ops(ops), .timestamp(timestamp));
   dec_counter_bank u_dec_counter_bank (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pass_strobe(pass_strobe),
      .up_op(ops[7:0]), .down_op(ops[15:8]), .block_op(ops[23:16]),
      .preset_select_operand(ops[31:24]), .reset_op(ops[39:32]), .freeze_reset_op(ops[47:40]),
      .freeze_count_op(ops[55:48]), .timestamp(timestamp), .count_above_setpoint(above),
      .count_equals_setpoint(equal), .count_below_setpoint(below),
      .power_fail_pin(power_fail_pin), .nv_we(nv_we), .nv_addr(nv_addr),
      .nv_wdata(nv_wdata), .irq(irq));
   // clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // byte address of a counter field
   function automatic logic [11:0] ca(input int n, input logic [2:0] f);
      return {`DEC_CNT_PAGE, 3'(n), f, 2'b00};
   endfunction
   // one word compare
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // all three flag vectors at once
   task automatic chk_flags(input string nm, input logic [23:0] e, input logic [23:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // single ahb transfer, holds each phase until hready is seen high
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= `DEC_HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {20'h00000, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // read and compare
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk_word(nm, e, rd);
      chk_word("hresp", 32'h0, {31'h0, hresp});
   endtask
   // one evaluation pass; notes the time word the bank samples, lets flags settle
   task automatic pass(input logic [55:0] v);
      want <= v;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      ts_exp = timestamp;
      repeat (2) @(posedge clk);
   endtask
   // verdict
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      conclude();
   end
   // main sequence
   initial begin
      {srst, hsel, hwrite, go, power_fail_pin} = 5'h10;
      {haddr, hwdata, htrans, want} = '0;
      rows = '{'{7'h00, 32'h0, 3'h1}, '{7'h01, 32'h1, 3'h1}, '{7'h00, 32'h1, 3'h1},
         '{7'h01, 32'h2, 3'h1}, '{7'h01, 32'h2, 3'h1}, '{7'h02, 32'h1, 3'h1},
         '{7'h00, 32'h1, 3'h1}, '{7'h03, 32'h1, 3'h1}, '{7'h08, 32'h5, 3'h4},
         '{7'h00, 32'h5, 3'h4}, '{7'h02, 32'h4, 3'h4}, '{7'h00, 32'h4, 3'h4},
         '{7'h02, 32'h3, 3'h2}, '{7'h40, 32'h3, 3'h2}, '{7'h01, 32'h4, 3'h4},
         '{7'h20, 32'h0, 3'h1}, '{7'h08, 32'h5, 3'h4}, '{7'h09, 32'h6, 3'h4},
         '{7'h18, 32'h5, 3'h4}, '{7'h08, 32'h5, 3'h4}, '{7'h0d, 32'h5, 3'h0},
         '{7'h00, 32'h5, 3'h4}};
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk_flags("flags at reset", 24'h0, {above, equal, below});
      rd_chk("ctrl at reset", `DEC_REG_CTRL, 32'h0);
      // same settings in every counter, then enable all
      for (int n = 0; n < 8; n++) begin
         bus(1'b1, ca(n, `DEC_F_PRESET), 32'h5);
         bus(1'b1, ca(n, `DEC_F_COMPARE), 32'h3);
      end
      rd_chk("compare", ca(7, `DEC_F_COMPARE), 32'h3);
      bus(1'b1, `DEC_REG_CTRL, 32'h0000_00ff);
      // table: the same operands to all eight counters, one counter read per row
      for (int i = 0; i < 22; i++) begin
         for (int k = 0; k < 7; k++) w[k*8 +: 8] = {8{rows[i].op[k]}};
         pass(w);
         rd_chk("acc", ca(i % 8, `DEC_F_ACC), rows[i].acc);
         chk_flags("flags", {{8{rows[i].fl[2]}}, {8{rows[i].fl[1]}}, {8{rows[i].fl[0]}}},
            {above, equal, below});
      end
      // freeze and count on counter 0 with its interrupt enabled
      // start from an empty status so the new capture is the only source
      bus(1'b1, `DEC_REG_IRQ_CLR, 32'h0001_ffff);
      bus(1'b1, `DEC_REG_IRQ_EN, 32'h0000_0001);
      rd_chk("irq enable", `DEC_REG_IRQ_EN, 32'h0000_0001);
      chk_word("irq idle", 32'h0, {31'h0, irq});
      pass(56'h01_00_00_00_00_00_00);
      rd_chk("frozen time", ca(0, `DEC_F_FTIME), ts_exp);
      rd_chk("frozen0", ca(0, `DEC_F_FROZEN), 32'h5);
      rd_chk("acc0 kept", ca(0, `DEC_F_ACC), 32'h5);
      chk_word("irq raised", 32'h1, {31'h0, irq});
      rd_chk("irq status", `DEC_REG_IRQ_STAT, 32'h0000_0001);
      bus(1'b1, `DEC_REG_IRQ_CLR, 32'h0001_ffff);
      repeat (2) @(posedge clk);
      chk_word("irq cleared", 32'h0, {31'h0, irq});
      // masked freeze on counter 1, freeze and reset on counter 2
      pass(56'h02_04_00_00_00_00_00);
      chk_word("irq masked", 32'h0, {31'h0, irq});
      rd_chk("irq status 2", `DEC_REG_IRQ_STAT, 32'h0000_0006);
      rd_chk("frozen2", ca(2, `DEC_F_FROZEN), 32'h5);
      rd_chk("acc2 cleared", ca(2, `DEC_F_ACC), 32'h0);
      rd_chk("clear reads 0", `DEC_REG_IRQ_CLR, 32'h0);
      rd_chk("unmapped", 12'h0fc, 32'h0);
      // wrap at both limits on counter 0
      bus(1'b1, ca(0, `DEC_F_PRESET), 32'h7fff_ffff);
      pass(56'h00_00_00_01_00_00_00);
      rd_chk("acc0 max", ca(0, `DEC_F_ACC), 32'h7fff_ffff);
      pass(56'h00_00_00_01_00_00_01);
      rd_chk("acc0 up wrap", ca(0, `DEC_F_ACC), 32'h8000_0000);
      chk_word("below0", 32'h1, {31'h0, below[0]});
      pass(56'h00_00_00_01_00_01_00);
      rd_chk("acc0 down wrap", ca(0, `DEC_F_ACC), 32'h7fff_ffff);
      // control power loss: sixteen words saved in order
      power_fail_pin <= 1'b1;
      nv_n = 0;
      repeat (40) begin
         @(posedge clk);
         if (nv_we === 1'b1) begin
            chk_word("nv addr", 32'(nv_n), {27'h0, nv_addr});
            if (nv_n == 0) chk_word("nv acc0", 32'h7fff_ffff, nv_wdata);
            if (nv_n == 8) chk_word("nv frozen0", 32'h5, nv_wdata);
            nv_n++;
         end
      end
      chk_word("nv words", 32'h0000_0010, 32'(nv_n));
      rd_chk("nv status", `DEC_REG_NV_STAT, 32'h2);
      // reset in mid-run: state and outputs back to their idle values
      srst <= 1'b1;
      power_fail_pin <= 1'b0;
      @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk_flags("flags after reset", 24'h0, {above, equal, below});
      chk_word("irq after reset", 32'h0, {31'h0, irq});
      rd_chk("acc0 after reset", ca(0, `DEC_F_ACC), 32'h0);
      rd_chk("status after reset", `DEC_REG_IRQ_STAT, 32'h0);
      rd_chk("nv after reset", `DEC_REG_NV_STAT, 32'h0);
      rd_chk("ctrl after reset", `DEC_REG_CTRL, 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
